// ### logic/cca_pkg.sv
// package: constants for the counter array block
`default_nettype none
package cca_pkg;
  localparam int NUM_MOD = 5;
  localparam int PIN_BASE = 3;
  localparam int COUNT_PIN = 2;
  localparam int WDT_MOD = 4;
  // sfr addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CNT_MODE = 8'h01;
  localparam logic [7:0] ADDR_CNT_LO = 8'h02;
  localparam logic [7:0] ADDR_CNT_HI = 8'h03;
  localparam logic [7:0] ADDR_MODE0 = 8'h08;
  localparam logic [7:0] ADDR_REG_LO0 = 8'h10;
  localparam logic [7:0] ADDR_REG_HI0 = 8'h18;
  // control/flag register fields
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  // counter mode register fields
  localparam int CNTM_IDLE_BIT = 7;
  localparam int CNTM_WDOG_BIT = 6;
  localparam int CNTM_SRC_LSB = 1;
  localparam int CNTM_OVFIE_BIT = 0;
  // module mode register fields
  localparam int MODE_IRQ_BIT = 0;
  localparam int MODE_PWM_BIT = 1;
  localparam int MODE_TOGGLE_BIT = 2;
  localparam int MODE_MATCH_BIT = 3;
  localparam int MODE_FALL_BIT = 4;
  localparam int MODE_RISE_BIT = 5;
  localparam int MODE_COMP_BIT = 6;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CNTM_RST = 8'h00;
  localparam logic [6:0] MODE_RST = 7'h00;
  localparam logic [7:0] MREG_RST = 8'h00;
  localparam logic PIN_RST = 1'b1;
  // prescale counts in oscillator cycles
  localparam logic [3:0] DIV_SLOW_6CLK = 4'h6;
  localparam logic [3:0] DIV_SLOW_12CLK = 4'hc;
  localparam logic [3:0] DIV_FAST_6CLK = 4'h2;
  localparam logic [3:0] DIV_FAST_12CLK = 4'h4;
  typedef enum logic [1:0] {
    SRC_SLOW = 2'b00,
    SRC_FAST = 2'b01,
    SRC_TMR0 = 2'b10,
    SRC_PIN = 2'b11
  } cca_src_e;
endpackage : cca_pkg
`default_nettype wire

// ### logic/cca_module.sv
// one capture/compare module of the counter array
`default_nettype none
module cca_module (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [6:0] mode,
  input wire logic [15:0] cnt,
  input wire logic cnt_adv,
  input wire logic pin_in,
  input wire logic we_lo,
  input wire logic we_hi,
  input wire logic [7:0] wdata,
  output logic [7:0] reg_lo,
  output logic [7:0] reg_hi,
  output logic pin_out,
  output logic flag_set,
  output logic match
);
  logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt;
  logic pin_r, pin_nxt, prev_r, prev_nxt;
  logic comp_on, pwm_mode, rise, fall, cap, wrap;

  // ----------------------------------------
  // capture, compare and pwm
  // ----------------------------------------
  always_comb begin
    comp_on = mode[cca_pkg::MODE_COMP_BIT];
    pwm_mode = mode[cca_pkg::MODE_PWM_BIT] & comp_on;
    prev_nxt = pin_in;
    rise = pin_in & ~prev_r;
    fall = ~pin_in & prev_r;
    cap = (rise & mode[cca_pkg::MODE_RISE_BIT]) |
          (fall & mode[cca_pkg::MODE_FALL_BIT]);
    match = comp_on & ~pwm_mode & cnt_adv & (cnt == {hi_r, lo_r});
    wrap = cnt_adv & (cnt[7:0] == 8'h00);
    flag_set = cap | (match & mode[cca_pkg::MODE_MATCH_BIT]);
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    if (cap) begin
      lo_nxt = cnt[7:0];
      hi_nxt = cnt[15:8];
    end else begin
      if (we_lo) begin
        lo_nxt = wdata;
      end
      if (we_hi) begin
        hi_nxt = wdata;
      end
      if (pwm_mode && wrap && !we_lo) begin
        lo_nxt = hi_r;
      end
    end
    pin_nxt = pin_r;
    if (pwm_mode) begin
      pin_nxt = (cnt[7:0] >= lo_r);
    end else if (match && mode[cca_pkg::MODE_TOGGLE_BIT]) begin
      pin_nxt = ~pin_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_r <= cca_pkg::MREG_RST;
      hi_r <= cca_pkg::MREG_RST;
      pin_r <= cca_pkg::PIN_RST;
      // matches the pulled-up idle pin, so no false edge after reset
      prev_r <= cca_pkg::PIN_RST;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      pin_r <= pin_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign reg_lo = lo_r;
  assign reg_hi = hi_r;
  assign pin_out = pin_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_capture;
    @(posedge clk) disable iff (!arst_n)
      cap |=> {hi_r, lo_r} == $past(cnt);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_toggle;
    @(posedge clk) disable iff (!arst_n)
      (match && mode[cca_pkg::MODE_TOGGLE_BIT]) |=> pin_r != $past(pin_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");

  property p_pwm;
    @(posedge clk) disable iff (!arst_n)
      pwm_mode |=> pin_r == ($past(cnt[7:0]) >= $past(lo_r));
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level wrong");

  property p_reload;
    @(posedge clk) disable iff (!arst_n)
      (pwm_mode && wrap && !we_lo && !cap) |=> lo_r == $past(hi_r);
  endproperty
  a_reload: assert property (p_reload) else $error("duty not reloaded");
endmodule : cca_module
`default_nettype wire

// ### logic/cca_top.sv
// counter array: shared counter, sfr port and five capture/compare modules
`default_nettype none
module cca_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic IDLE,
  input wire logic CLK12_MODE,
  input wire logic TMR0_OVF,
  input wire logic [7:0] PORT1_IN,
  output logic [7:0] PORT1_OUT,
  output logic IRQ,
  output logic WDT_RESET
);
  localparam int NM = cca_pkg::NUM_MOD;

  logic run_r, run_nxt, ovf_flag_r, ovf_flag_nxt;
  logic [NM-1:0] mod_flag_r, mod_flag_nxt;
  logic idle_stop_r, idle_stop_nxt, wdog_en_r, wdog_en_nxt, ovf_ie_r, ovf_ie_nxt;
  logic [1:0] src_r, src_nxt;
  logic [6:0] mode_r [NM];
  logic [6:0] mode_nxt [NM];
  logic [3:0] pre_r, pre_nxt, div;
  logic cin_prev_r, cin_prev_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic cnt_adv_r, cnt_adv_nxt;
  logic run_eff, tick, inc, ovf, wr_cnt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt, wdt_r, wdt_nxt;
  logic [NM-1:0] we_lo, we_hi, flag_set, match, pin_out;
  logic [7:0] reg_lo [NM];
  logic [7:0] reg_hi [NM];
  logic [NM-1:0] irq_en;

  // ----------------------------------------
  // count source and prescaler
  // ----------------------------------------
  always_comb begin
    run_eff = run_r & ~(idle_stop_r & IDLE);
    cin_prev_nxt = PORT1_IN[cca_pkg::COUNT_PIN];
    if (src_r == cca_pkg::SRC_FAST) begin
      div = CLK12_MODE ? cca_pkg::DIV_FAST_12CLK : cca_pkg::DIV_FAST_6CLK;
    end else begin
      div = CLK12_MODE ? cca_pkg::DIV_SLOW_12CLK : cca_pkg::DIV_SLOW_6CLK;
    end
    pre_nxt = pre_r + 4'h1;
    tick = 1'b0;
    unique case (src_r)
      cca_pkg::SRC_SLOW, cca_pkg::SRC_FAST: begin
        if (pre_r >= div - 4'h1) begin
          tick = 1'b1;
          pre_nxt = 4'h0;
        end
      end
      cca_pkg::SRC_TMR0: begin
        tick = TMR0_OVF;
      end
      cca_pkg::SRC_PIN: begin
        tick = cin_prev_r & ~PORT1_IN[cca_pkg::COUNT_PIN];
      end
    endcase
    if (!run_eff) begin
      pre_nxt = 4'h0;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_r <= 4'h0;
      cin_prev_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      cin_prev_r <= cin_prev_nxt;
    end
  end

  // ----------------------------------------
  // shared 16-bit counter
  // ----------------------------------------
  always_comb begin
    inc = tick & run_eff;
    ovf = inc & (cnt_r == 16'hffff);
    wr_cnt = SFR_WR & ((SFR_ADDR == cca_pkg::ADDR_CNT_LO) |
                       (SFR_ADDR == cca_pkg::ADDR_CNT_HI));
    cnt_nxt = cnt_r;
    if (inc) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (SFR_WR && SFR_ADDR == cca_pkg::ADDR_CNT_LO) begin
      cnt_nxt[7:0] = SFR_WDATA;
    end
    if (SFR_WR && SFR_ADDR == cca_pkg::ADDR_CNT_HI) begin
      cnt_nxt[15:8] = SFR_WDATA;
    end
    cnt_adv_nxt = inc & ~wr_cnt;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_r <= 16'h0000;
      cnt_adv_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cnt_adv_r <= cnt_adv_nxt;
    end
  end

  // ----------------------------------------
  // control, flags and mode registers
  // ----------------------------------------
  always_comb begin
    run_nxt = run_r;
    ovf_flag_nxt = ovf_flag_r;
    mod_flag_nxt = mod_flag_r;
    idle_stop_nxt = idle_stop_r;
    wdog_en_nxt = wdog_en_r;
    src_nxt = src_r;
    ovf_ie_nxt = ovf_ie_r;
    mode_nxt = mode_r;
    if (SFR_WR && SFR_ADDR == cca_pkg::ADDR_CTRL) begin
      run_nxt = SFR_WDATA[cca_pkg::CTRL_RUN_BIT];
      ovf_flag_nxt = SFR_WDATA[cca_pkg::CTRL_OVF_BIT];
      mod_flag_nxt = SFR_WDATA[NM-1:0];
    end
    if (SFR_WR && SFR_ADDR == cca_pkg::ADDR_CNT_MODE) begin
      idle_stop_nxt = SFR_WDATA[cca_pkg::CNTM_IDLE_BIT];
      wdog_en_nxt = SFR_WDATA[cca_pkg::CNTM_WDOG_BIT];
      src_nxt = SFR_WDATA[cca_pkg::CNTM_SRC_LSB +: 2];
      ovf_ie_nxt = SFR_WDATA[cca_pkg::CNTM_OVFIE_BIT];
    end
    for (int n = 0; n < NM; n++) begin
      if (SFR_WR && SFR_ADDR == cca_pkg::ADDR_MODE0 + 8'(n)) begin
        mode_nxt[n] = SFR_WDATA[6:0];
      end
    end
    // hardware set wins over a software clear
    if (ovf) begin
      ovf_flag_nxt = 1'b1;
    end
    mod_flag_nxt = mod_flag_nxt | flag_set;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      run_r <= cca_pkg::CTRL_RST[cca_pkg::CTRL_RUN_BIT];
      ovf_flag_r <= cca_pkg::CTRL_RST[cca_pkg::CTRL_OVF_BIT];
      mod_flag_r <= cca_pkg::CTRL_RST[NM-1:0];
      idle_stop_r <= cca_pkg::CNTM_RST[cca_pkg::CNTM_IDLE_BIT];
      wdog_en_r <= cca_pkg::CNTM_RST[cca_pkg::CNTM_WDOG_BIT];
      src_r <= cca_pkg::CNTM_RST[cca_pkg::CNTM_SRC_LSB +: 2];
      ovf_ie_r <= cca_pkg::CNTM_RST[cca_pkg::CNTM_OVFIE_BIT];
      for (int n = 0; n < NM; n++) begin
        mode_r[n] <= cca_pkg::MODE_RST;
      end
    end else begin
      run_r <= run_nxt;
      ovf_flag_r <= ovf_flag_nxt;
      mod_flag_r <= mod_flag_nxt;
      idle_stop_r <= idle_stop_nxt;
      wdog_en_r <= wdog_en_nxt;
      src_r <= src_nxt;
      ovf_ie_r <= ovf_ie_nxt;
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------
  // capture/compare modules
  // ----------------------------------------
  for (genvar g = 0; g < NM; g++) begin : g_mod
    assign we_lo[g] = SFR_WR & (SFR_ADDR == cca_pkg::ADDR_REG_LO0 + 8'(g));
    assign we_hi[g] = SFR_WR & (SFR_ADDR == cca_pkg::ADDR_REG_HI0 + 8'(g));
    assign irq_en[g] = mode_r[g][cca_pkg::MODE_IRQ_BIT];
    cca_module u_mod (
      .clk(CLK),
      .arst_n(ARST_N),
      .mode(mode_r[g]),
      .cnt(cnt_r),
      .cnt_adv(cnt_adv_r),
      .pin_in(PORT1_IN[cca_pkg::PIN_BASE + g]),
      .we_lo(we_lo[g]),
      .we_hi(we_hi[g]),
      .wdata(SFR_WDATA),
      .reg_lo(reg_lo[g]),
      .reg_hi(reg_hi[g]),
      .pin_out(pin_out[g]),
      .flag_set(flag_set[g]),
      .match(match[g])
    );
  end

  // pins below the module pins idle high
  assign PORT1_OUT = {pin_out, 3'b111};

  // ----------------------------------------
  // read port, interrupt and watchdog
  // ----------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (SFR_ADDR)
      cca_pkg::ADDR_CTRL: begin
        rdata_nxt = {ovf_flag_r, run_r, 1'b0, mod_flag_r};
      end
      cca_pkg::ADDR_CNT_MODE: begin
        rdata_nxt = {idle_stop_r, wdog_en_r, 3'b000, src_r, ovf_ie_r};
      end
      cca_pkg::ADDR_CNT_LO: begin
        rdata_nxt = cnt_r[7:0];
      end
      cca_pkg::ADDR_CNT_HI: begin
        rdata_nxt = cnt_r[15:8];
      end
      default: begin
        for (int n = 0; n < NM; n++) begin
          if (SFR_ADDR == cca_pkg::ADDR_MODE0 + 8'(n)) begin
            rdata_nxt = {1'b0, mode_r[n]};
          end
          if (SFR_ADDR == cca_pkg::ADDR_REG_LO0 + 8'(n)) begin
            rdata_nxt = reg_lo[n];
          end
          if (SFR_ADDR == cca_pkg::ADDR_REG_HI0 + 8'(n)) begin
            rdata_nxt = reg_hi[n];
          end
        end
      end
    endcase
    irq_nxt = (ovf_flag_r & ovf_ie_r) | (|(mod_flag_r & irq_en));
    wdt_nxt = wdog_en_r & match[cca_pkg::WDT_MOD] &
              mode_r[cca_pkg::WDT_MOD][cca_pkg::MODE_MATCH_BIT];
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      wdt_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      wdt_r <= wdt_nxt;
    end
  end

  assign SFR_RDATA = rdata_r;
  assign IRQ = irq_r;
  assign WDT_RESET = wdt_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_stopped;
    @(posedge CLK) disable iff (!ARST_N)
      (!run_r && !wr_cnt) |=> cnt_r == $past(cnt_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while off");

  property p_idle;
    @(posedge CLK) disable iff (!ARST_N)
      (idle_stop_r && IDLE) |=> !cnt_adv_r;
  endproperty
  a_idle: assert property (p_idle) else $error("counter ran in idle");

  property p_wrap;
    @(posedge CLK) disable iff (!ARST_N)
      (ovf && !wr_cnt) |=> (cnt_r == 16'h0000) && ovf_flag_r;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow not handled");

  property p_ovf_sticky;
    @(posedge CLK) disable iff (!ARST_N)
      (ovf_flag_r && !(SFR_WR && SFR_ADDR == cca_pkg::ADDR_CTRL)) |=> ovf_flag_r;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_mod_flag;
    @(posedge CLK) disable iff (!ARST_N)
      (|flag_set) |=> (mod_flag_r & $past(flag_set)) == $past(flag_set);
  endproperty
  a_mod_flag: assert property (p_mod_flag) else $error("module flag not set");

  property p_irq;
    @(posedge CLK) disable iff (!ARST_N)
      (|(mod_flag_r & irq_en)) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("module interrupt missing");

  property p_wdt;
    @(posedge CLK) disable iff (!ARST_N)
      (wdog_en_r && match[4] && mode_r[4][cca_pkg::MODE_MATCH_BIT]) |=> WDT_RESET;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog reset missing");

  property p_slow_rate;
    @(posedge CLK) disable iff (!ARST_N)
      (inc && src_r == cca_pkg::SRC_SLOW && !CLK12_MODE && run_eff) |=>
        !inc [*5];
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow rate wrong");
endmodule : cca_top
`default_nettype wire

// ### verif/cca_pins.sv
// partner model: external drivers of the port 1 pins
`default_nettype none
module cca_pins (
  input wire logic clk,
  output logic [7:0] port
);
  timeunit 1ns;
  timeprecision 1ps;
  // pulled-up pins idle high
  initial begin
    port = 8'hff;
  end
  // module n drives port bit 3 + n
  task automatic set_mod(input int m, input logic v);
    @(posedge clk);
    port[3 + m] <= v;
  endtask : set_mod
  // one falling edge on the count pin, back high after two cycles
  task automatic fall_count();
    @(posedge clk);
    port[2] <= 1'b0;
    repeat (2) @(posedge clk);
    port[2] <= 1'b1;
  endtask : fall_count
endmodule : cca_pins
`default_nettype wire

// ### verif/tb_top.sv
// bench: counter array driven through its registers and port 1 pins
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, sfr_wr, idle, clk12, tovf, irq, wdt, hit, old;
  logic [7:0] addr, wdata, rdata, p1_in, p1_out, rv, md;
  logic [15:0] v, cap;
  int fail_count = 0;
  int cmp_count = 0;
  int wdt_n = 0;
  int mcnt, n, dv;
  cca_top DUT (.CLK(clk), .ARST_N(arst_n), .SFR_ADDR(addr), .SFR_WR(sfr_wr),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .IDLE(idle), .CLK12_MODE(clk12),
    .TMR0_OVF(tovf), .PORT1_IN(p1_in), .PORT1_OUT(p1_out), .IRQ(irq), .WDT_RESET(wdt));
  cca_pins pins (.clk(clk), .port(p1_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wdt === 1'b1) begin
      wdt_n <= wdt_n + 1;
    end
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask : get
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task automatic tick(input int k, input bit live);
    repeat (k) begin
      @(posedge clk);
      tovf <= 1'b1;
      @(posedge clk);
      tovf <= 1'b0;
    end
    if (live) begin
      mcnt = (mcnt + k) & 32'h0000_ffff;
    end
  endtask : tick
  task automatic setcnt(input logic [15:0] c);
    put(8'h02, c[7:0]);
    put(8'h03, c[15:8]);
    mcnt = int'(c);
  endtask : setcnt
  task automatic cntchk();
    get(8'h02, rv);
    chk(rv, mcnt[7:0]);
    get(8'h03, rv);
    chk(rv, mcnt[15:8]);
  endtask : cntchk
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    sfr_wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    idle = 1'b0;
    clk12 = 1'b0;
    tovf = 1'b0;
    void'($urandom(89));
    repeat (12) @(posedge clk);
    chk(p1_out, 8'hff);
    arst_n <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      get(8'(a), rv);
      chk(rv, 8'h00);
    end
    put(8'h05, 8'ha5);
    get(8'h05, rv);
    chk(rv, 8'h00);
    put(8'h08, 8'hff);
    get(8'h08, rv);
    chk(rv, 8'h7f);
    put(8'h08, 8'h00);
    for (int s = 0; s < 4; s++) begin
      put(8'h01, {6'h00, s[0], 1'b0});
      clk12 <= s[1];
      dv = s[0] ? (s[1] ? 4 : 2) : (s[1] ? 12 : 6);
      setcnt(16'h0000);
      put(8'h00, 8'h40);
      repeat (120) @(posedge clk);
      put(8'h00, 8'h00);
      get(8'h02, rv);
      n = int'(rv) - 122 / dv;
      chk({7'h00, n < -2 || n > 2}, 8'h00);
    end
    clk12 <= 1'b0;
    put(8'h01, 8'h06);
    setcnt(16'h0000);
    put(8'h00, 8'h40);
    repeat (3) pins.fall_count();
    mcnt = 3;
    put(8'h00, 8'h00);
    cntchk();
    put(8'h01, 8'h85);
    setcnt(16'hfffe);
    put(8'h00, 8'h40);
    idle <= 1'b1;
    tick(3, 0);
    idle <= 1'b0;
    tick(2, 1);
    wt(3);
    chk({7'h00, irq}, 8'h01);
    tick(1, 1);
    get(8'h00, rv);
    chk(rv, 8'hc0);
    put(8'h00, 8'h00);
    tick(2, 0);
    cntchk();
    wt(3);
    chk({7'h00, irq}, 8'h00);
    put(8'h01, 8'h04);
    for (int m = 0; m < 5; m++) begin
      md = (m % 3 == 0) ? 8'h21 : (m % 3 == 1) ? 8'h11 : 8'h31;
      put(8'h08 + 8'(m), md);
      cap = 16'h0000;
      for (int e = 0; e < 2; e++) begin
        v = 16'($urandom);
        setcnt(v);
        pins.set_mod(m, e[0]);
        wt(3);
        hit = e[0] ? md[5] : md[4];
        if (hit) begin
          cap = v;
        end
        chk({7'h00, irq}, {7'h00, hit});
        get(8'h10 + 8'(m), rv);
        chk(rv, cap[7:0]);
        get(8'h18 + 8'(m), rv);
        chk(rv, cap[15:8]);
        get(8'h00, rv);
        chk(rv, hit ? 8'h01 << m : 8'h00);
        put(8'h00, 8'h00);
      end
      put(8'h08 + 8'(m), 8'h00);
    end
    for (int m = 0; m < 4; m++) begin
      md = (m == 3) ? 8'h0d : 8'h4d;
      hit = (m != 3);
      put(8'h08 + 8'(m), md);
      // all ones would wrap and set the overflow flag in the read-back
      v = 16'($urandom_range(0, 65534));
      setcnt(v);
      put(8'h10 + 8'(m), 8'(v + 1));
      put(8'h18 + 8'(m), 8'((v + 1) >> 8));
      put(8'h00, 8'h40);
      wt(0);
      old = p1_out[3 + m];
      tick(1, 1);
      wt(4);
      chk({7'h00, p1_out[3 + m]}, {7'h00, old ^ hit});
      chk({7'h00, irq}, {7'h00, hit});
      get(8'h00, rv);
      chk(rv, hit ? 8'h40 | (8'h01 << m) : 8'h40);
      put(8'h00, 8'h00);
      put(8'h08 + 8'(m), 8'h00);
    end
    for (int e = 0; e < 2; e++) begin
      put(8'h01, (e == 1) ? 8'h44 : 8'h04);
      put(8'h0c, 8'h48);
      v = 16'($urandom);
      setcnt(v);
      put(8'h14, 8'(v + 1));
      put(8'h1c, 8'((v + 1) >> 8));
      put(8'h00, 8'h40);
      n = wdt_n;
      tick(1, 1);
      wt(3);
      chk(8'(wdt_n - n), 8'(e));
      put(8'h00, 8'h00);
    end
    put(8'h0c, 8'h00);
    put(8'h01, 8'h04);
    put(8'h0a, 8'h42);
    put(8'h12, 8'h80);
    put(8'h1a, 8'h40);
    for (int i = 0; i < 3; i++) begin
      md = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($urandom_range(1, 255));
      setcnt({8'h00, md});
      wt(2);
      chk({7'h00, p1_out[5]}, {7'h00, md >= 8'h80});
    end
    setcnt(16'h00ff);
    put(8'h00, 8'h40);
    tick(1, 1);
    put(8'h00, 8'h00);
    get(8'h12, rv);
    chk(rv, 8'h40);
    chk({7'h00, p1_out[5]}, 8'h00);
    tally_and_finish();
  end
  initial begin
    #100us;
    fail_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
